// *** bench/cpu_mem_model.sv ***
// program and data memory model answering the execute unit
`timescale 1ns/10ps
`default_nettype none
module cpu_mem_model
    import cpu_tail_pkg::*;
(
    input wire logic clk,
    input wire mem_req_t mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    ////////////////////////////////////////////////////////////////
    // answers only while read; an idle bus shows the inverse of the last byte
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last;
    // stores and read history on the clock edge
    always @(posedge clk) begin
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
        if (mem_req.rd) begin
            last <= mem[mem_req.addr];
        end
    end
endmodule : cpu_mem_model
`default_nettype wire

// *** bench/cpu_tail_props.sv ***
// assertion checker for the tail opcode execute unit
`timescale 1ns/10ps
`default_nettype none
module cpu_tail_props
    import cpu_tail_pkg::*;
#(
    parameter logic [15:0] TRAP_VEC = TRAP_VECTOR
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] mem_rdata,
    input wire logic irq_pending,
    input wire mem_req_t mem_req,
    input wire cpu_regs_t regs,
    input wire logic halted,
    input wire logic busy,
    input wire logic illegal_op,
    input wire logic [15:0] branch_target,
    input wire logic [7:0] bit_operand_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // opcode byte on the bus at a fetch that follows an idle cycle
    sequence s_op(logic [7:0] op);
        mem_req.rd && !$past(busy) && mem_rdata == op;
    endsequence
    // any opcode fetch on the bus
    sequence s_fetch;
        mem_req.rd && !$past(busy);
    endsequence
    property p_push_page;
        mem_req.wr |-> mem_req.addr[15:8] == SP_STACK_PAGE;
    endproperty
    a_push_page: assert property (p_push_page) else $error("store outside stack page");
    property p_push_desc;
        mem_req.wr ##1 mem_req.wr |-> mem_req.addr[7:0] == $past(mem_req.addr[7:0]) - 8'h01;
    endproperty
    a_push_desc: assert property (p_push_desc) else $error("stack pushes not descending");
    property p_push_five;
        s_op(OP_SOFTWARE_TRAP) |-> ##2 mem_req.wr[*5] ##1 !mem_req.wr;
    endproperty
    a_push_five: assert property (p_push_five) else $error("trap did not store five bytes");
    property p_vec_read;
        s_op(OP_SOFTWARE_TRAP) |-> ##7 (mem_req.rd && mem_req.addr == TRAP_VEC)
            ##1 (mem_req.rd && mem_req.addr == TRAP_VEC + 16'd1);
    endproperty
    a_vec_read: assert property (p_vec_read) else $error("trap vector not read");
    property p_tax_flags;
        s_op(OP_ACC_TO_INDEX) |=> $stable(regs.flag_register)[*3];
    endproperty
    a_tax_flags: assert property (p_tax_flags) else $error("flags moved on acc copy");
    property p_txa_flags;
        s_op(OP_INDEX_TO_ACC) |=> $stable(regs.flag_register)[*3];
    endproperty
    a_txa_flags: assert property (p_txa_flags) else $error("flags moved on index copy");
    property p_test_acc;
        s_op(OP_TEST_ACC) |-> ##2 (regs.flag_register[FLAG_Z] == (regs.acc == 8'h00)
            && regs.flag_register[FLAG_N] == regs.acc[7]);
    endproperty
    a_test_acc: assert property (p_test_acc) else $error("acc test flags wrong");
    property p_wait_mask;
        s_op(OP_WAIT) ##0 !irq_pending |-> ##1 (halted && !regs.flag_register[FLAG_I]);
    endproperty
    a_wait_mask: assert property (p_wait_mask) else $error("wait did not halt with mask clear");
    property p_halt_hold;
        halted && !irq_pending |=> halted;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt left without wake");
    property p_halt_quiet;
        halted |-> !mem_req.rd && !mem_req.wr;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("bus active while halted");
    property p_tax_copy;
        s_op(OP_ACC_TO_INDEX) |=> (regs.index == $past(regs.acc)) ##1 s_fetch;
    endproperty
    a_tax_copy: assert property (p_tax_copy) else $error("acc copy wrong or not two cycles");
    property p_txa_copy;
        s_op(OP_INDEX_TO_ACC) |=> (regs.acc == $past(regs.index)) ##1 s_fetch;
    endproperty
    a_txa_copy: assert property (p_txa_copy) else $error("index copy wrong or not two cycles");
    property p_trap_cycles;
        s_op(OP_SOFTWARE_TRAP) |-> ##9 regs.flag_register[FLAG_I] ##1 s_fetch;
    endproperty
    a_trap_cycles: assert property (p_trap_cycles) else $error("trap length or mask wrong");
    property p_test_dir_cycles;
        s_op(OP_TEST_DIR) |-> ##4 s_fetch;
    endproperty
    a_test_dir_cycles: assert property (p_test_dir_cycles) else $error("direct test length wrong");
    property p_test_idx_cycles;
        s_op(OP_TEST_IDX) |-> ##3 s_fetch;
    endproperty
    a_test_idx_cycles: assert property (p_test_idx_cycles) else $error("index test length wrong");
    // main scenarios reached
    c_trap: cover property (mem_req.wr ##1 mem_req.wr);
    c_halt: cover property (halted ##1 !halted);
    c_illegal: cover property (illegal_op);
endmodule : cpu_tail_props
bind cpu_tail_opcode_execute cpu_tail_props #(.TRAP_VEC(TRAP_VEC)) cpu_tail_props_i (.clk(clk), .rst_n(rst_n),
    .mem_rdata(mem_rdata), .irq_pending(irq_pending), .mem_req(mem_req), .regs(regs), .halted(halted),
    .busy(busy), .illegal_op(illegal_op), .branch_target(branch_target), .bit_operand_addr(bit_operand_addr));
`default_nettype wire

// *** bench/tb_cpu_tail_opcode_execute.sv ***
// self-checking testbench for the tail opcode execute unit
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_tail_opcode_execute
    import cpu_tail_pkg::*;
;
    logic clk;
    logic rst_n;
    logic irq_pending;
    logic [7:0] mem_rdata;
    mem_req_t mem_req;
    cpu_regs_t regs;
    logic halted;
    logic busy;
    logic illegal_op;
    logic [15:0] branch_target;
    logic [7:0] bit_operand_addr;
    logic [23:0] wq[$];
    logic [23:0] sb_e;
    logic [7:0] r [1:5];
    int err_count = 0;
    int checks_done = 0;
    int cyc_now = 0;
    int cyc_last = 0;
    integer seed = 53635;
    ////////////////////////////////////////////////////////////////
    cpu_tail_opcode_execute cpu_tail_opcode_execute_i (.clk(clk), .rst_n(rst_n), .mem_rdata(mem_rdata),
        .irq_pending(irq_pending), .mem_req(mem_req), .regs(regs), .halted(halted), .busy(busy),
        .illegal_op(illegal_op), .branch_target(branch_target), .bit_operand_addr(bit_operand_addr));
    cpu_mem_model cpu_mem_model_i (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    // clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic wait_fetch(input logic [15:0] a);
        bit hit;
        hit = 1'b0;
        for (int i = 0; i < 60 && !hit; i++) begin
            @(negedge clk);
            hit = (mem_req.rd === 1'b1) && (mem_req.addr === a);
        end
        if (!hit) begin
            $display("mismatch fetch expected %h seen none", a);
            err_count++;
            test_done();
        end
    endtask : wait_fetch
    task automatic wait_high(ref logic s, input string name);
        for (int i = 0; i < 30 && s !== 1'b1; i++) begin
            @(negedge clk);
        end
        chk(name, 16'h0001, {15'h0000, s});
        if (s !== 1'b1) begin
            test_done();
        end
    endtask : wait_high
    task automatic step(input logic [15:0] a, input logic [7:0] f, input int n);
        wait_fetch(a);
        chk("cycles", 16'(n), 16'(cyc_now - cyc_last));
        cyc_last = cyc_now;
        chk("busy", 16'h0001, {15'h0000, busy});
        chk("flags", {8'h00, f}, {8'h00, regs.flag_register});
    endtask : step
    task automatic ld(input logic [15:0] a, input logic [7:0] b[]);
        foreach (b[i]) cpu_mem_model_i.mem[a + 16'(i)] = b[i];
    endtask : ld
    function automatic logic [7:0] fl(input logic i, input logic [7:0] v);
        return {4'h0, i, v[7], v == 8'h00, 1'b0};
    endfunction : fl
    ////////////////////////////////////////////////////////////////
    // cycle count for instruction lengths
    always @(posedge clk) begin
        cyc_now <= cyc_now + 1;
    end
    // scoreboard: each store against the oldest expected push
    always @(negedge clk) begin
        if (rst_n && mem_req.wr === 1'b1) begin
            sb_e = (wq.size() > 0) ? wq.pop_front() : 24'hxxxx_xx;
            chk("store addr", sb_e[23:8], mem_req.addr);
            chk("store data", {8'h00, sb_e[7:0]}, {8'h00, mem_req.wdata});
        end
    end
    // program, stimulus and register checks
    initial begin
        rst_n = 1'b0;
        irq_pending = 1'b0;
        for (int i = 1; i <= 5; i++) r[i] = 8'($random(seed));
        ld(16'h1FFC, '{8'h30, 8'h00, 8'h3D, 8'h40, 8'h6D, 8'h50, 8'hCD, 8'h12, 8'h34, 8'h97, 8'h9F, 8'h4D, 8'h83});
        ld(16'h3000, '{8'h7D, 8'hDD, 8'h01, 8'h00, 8'h03, 8'h77, 8'hF0});
        ld(16'h2FF7, '{8'h8F, 8'h5D, 8'h42, 8'h8F});
        ld(16'h0040, '{r[1]});
        ld(16'h0050, '{r[2]});
        ld(16'h1234, '{r[3]});
        ld(16'h0000, '{r[4]});
        ld(16'h0100, '{r[5]});
        wq = '{{16'h00FF, 8'h09}, {16'h00FE, 8'h20}, {16'h00FD, 8'h00}, {16'h00FC, 8'h00}, {16'h00FB, 8'h0A}};
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        wait_fetch(16'h1FFE);
        cyc_last = cyc_now;
        step(16'h2000, fl(1'b1, r[1]), CYC_TEST_DIR);
        step(16'h2002, fl(1'b1, r[2]), CYC_TEST_IX1);
        step(16'h2005, fl(1'b1, r[3]), CYC_TEST_EXT);
        step(16'h2006, fl(1'b1, r[3]), CYC_COPY);
        step(16'h2007, fl(1'b1, r[3]), CYC_COPY);
        step(16'h2008, fl(1'b1, 8'h00), CYC_TEST_REG);
        step(16'h3000, fl(1'b1, 8'h00), CYC_TRAP);
        chk("stack pointer", 16'h00FA, {8'h00, regs.sp});
        step(16'h3001, fl(1'b1, r[4]), CYC_TEST_IX);
        step(16'h3004, fl(1'b1, r[5]), CYC_TEST_IX2);
        step(16'h2FF7, fl(1'b1, r[5]), CYC_BIT_BRANCH);
        chk("bit address", 16'h0077, {8'h00, bit_operand_addr});
        chk("branch target", 16'h2FF7, branch_target);
        wait_high(halted, "halted");
        chk("mask", 16'h0000, {15'h0000, regs.flag_register[FLAG_I]});
        repeat (6) @(negedge clk);
        chk("still halted", 16'h0001, {15'h0000, halted});
        chk("busy idle", 16'h0000, {15'h0000, busy});
        irq_pending = 1'b1;
        wait_fetch(16'h2FF8);
        irq_pending = 1'b0;
        wait_fetch(16'h2FF9);
        chk("index test flags", 16'h0001, {14'h0000, regs.flag_register[FLAG_N:FLAG_Z]});
        wait_high(illegal_op, "illegal");
        chk("acc kept", 16'h0000, {8'h00, regs.acc});
        chk("pending stores", 16'h0000, 16'(wq.size()));
        test_done();
    end
endmodule : tb_cpu_tail_opcode_execute
`default_nettype wire

// *** rtl/cpu_tail_opcode_execute.sv ***
// tail group execute unit: trap, copies, test, wait, operand fetch modes
`timescale 1ns/10ps
`default_nettype none
module cpu_tail_opcode_execute
    import cpu_tail_pkg::*;
#(
    parameter logic [15:0] TRAP_VEC = TRAP_VECTOR
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] mem_rdata,
    input wire logic irq_pending,
    output mem_req_t mem_req,
    output cpu_regs_t regs,
    output logic halted,
    output logic busy,
    output logic illegal_op,
    output logic [15:0] branch_target,
    output logic [7:0] bit_operand_addr
);
    typedef enum {
        st_fetch, st_decode, st_op1, st_op2, st_read, st_exec, st_push, st_vec_hi, st_vec_lo, st_wait_halt, st_pad
    } state_t;

    state_t state, next_state;
    cpu_regs_t next_regs;
    mem_req_t next_mem_req;
    logic [7:0] opcode, next_opcode;
    logic [15:0] ea, next_ea;
    logic [2:0] push_idx, next_push_idx;
    logic [3:0] cyc_left, next_cyc_left;
    logic next_halted, next_illegal;
    logic [15:0] next_branch_target;
    logic [7:0] next_bit_addr;
    addr_mode_t mode;
    logic [3:0] cycles;
    logic known;

    tail_opcode_decode u_decode (
        .opcode(next_opcode),
        .mode(mode),
        .cycles(cycles),
        .known(known)
    );

    // update negative and zero from a value, leave other flags
    function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] r;
        r = f;
        r[FLAG_N] = v[7];
        r[FLAG_Z] = (v == 8'h00);
        return r;
    endfunction : nz_flags

    // byte to stack for each push step
    function automatic logic [7:0] push_byte(input cpu_regs_t r, input logic [2:0] i);
        logic [7:0] b;
        b = r.flag_register;
        unique case (i)
            3'd0: b = r.pc[7:0];
            3'd1: b = r.pc[15:8];
            3'd2: b = r.index;
            3'd3: b = r.acc;
            default: b = r.flag_register;
        endcase
        return b;
    endfunction : push_byte

    ////////////////////////////////////////////////////////////////////////
    // next state and datapath
    always_comb begin
        next_state = state;
        next_regs = regs;
        next_opcode = opcode;
        next_ea = ea;
        next_push_idx = push_idx;
        next_cyc_left = (cyc_left != 4'd0) ? cyc_left - 4'd1 : 4'd0;
        next_halted = halted;
        next_illegal = 1'b0;
        next_branch_target = branch_target;
        next_bit_addr = bit_operand_addr;
        next_mem_req = '0;
        unique case (state)
            st_fetch: begin
                next_mem_req.addr = regs.pc;
                next_mem_req.rd = 1'b1;
                next_regs.pc = regs.pc + 16'd1;
                next_state = st_decode;
            end
            st_decode: begin
                next_opcode = mem_rdata;
                next_cyc_left = cycles - 4'd2;
                next_ea = 16'h0000;
                if (!known) begin
                    next_illegal = 1'b1;
                    next_state = st_fetch;
                end else if (mem_rdata == OP_ACC_TO_INDEX) begin
                    // two-cycle copies finish in decode, flags untouched
                    next_regs.index = regs.acc;
                    next_state = st_fetch;
                end else if (mem_rdata == OP_INDEX_TO_ACC) begin
                    next_regs.acc = regs.index;
                    next_state = st_fetch;
                end else if (mem_rdata == OP_WAIT) begin
                    next_regs.flag_register[FLAG_I] = 1'b0;
                    next_halted = 1'b1;
                    next_state = st_wait_halt;
                end else if (mem_rdata == OP_SOFTWARE_TRAP) begin
                    next_push_idx = 3'd0;
                    next_state = st_push;
                end else if (mode == implied_operand_mode) begin
                    next_state = st_exec;
                end else if (mode == indexed_no_offset_mode) begin
                    next_ea = {8'h00, regs.index};
                    next_state = st_read;
                end else begin
                    next_mem_req.addr = regs.pc;
                    next_mem_req.rd = 1'b1;
                    next_regs.pc = regs.pc + 16'd1;
                    next_state = st_op1;
                end
            end
            st_op1: begin
                unique case (mode)
                    direct_mode: next_ea = {8'h00, mem_rdata};
                    indexed_byte_offset_mode: next_ea = {8'h00, mem_rdata} + {8'h00, regs.index};
                    default: next_ea = {mem_rdata, 8'h00};
                endcase
                if (mode == bit_branch_mode) begin
                    next_bit_addr = mem_rdata;
                end
                if (mode == full_address_mode || mode == indexed_word_offset_mode || mode == bit_branch_mode) begin
                    next_mem_req.addr = regs.pc;
                    next_mem_req.rd = 1'b1;
                    next_regs.pc = regs.pc + 16'd1;
                    next_state = st_op2;
                end else if (mode == direct_mode) begin
                    // direct operand read goes out at once to keep the count
                    next_mem_req.addr = {8'h00, mem_rdata};
                    next_mem_req.rd = 1'b1;
                    next_state = st_exec;
                end else begin
                    next_state = st_read;
                end
            end
            st_op2: begin
                if (mode == bit_branch_mode) begin
                    next_branch_target = regs.pc + {{8{mem_rdata[7]}}, mem_rdata};
                    next_state = st_pad;
                end else if (mode == indexed_word_offset_mode) begin
                    next_ea = {ea[15:8], mem_rdata} + {8'h00, regs.index};
                    next_state = st_read;
                end else begin
                    next_ea = {ea[15:8], mem_rdata};
                    next_mem_req.addr = {ea[15:8], mem_rdata};
                    next_mem_req.rd = 1'b1;
                    next_state = st_exec;
                end
            end
            st_read: begin
                next_mem_req.addr = ea;
                next_mem_req.rd = 1'b1;
                next_state = st_exec;
            end
            st_exec: begin
                next_state = (cyc_left <= 4'd1) ? st_fetch : st_pad;
                unique case (opcode)
                    OP_TEST_ACC: next_regs.flag_register = nz_flags(regs.flag_register, regs.acc);
                    OP_TEST_IDX: next_regs.flag_register = nz_flags(regs.flag_register, regs.index);
                    default: begin
                        if (mode != bit_branch_mode) begin
                            next_regs.flag_register = nz_flags(regs.flag_register, mem_rdata);
                        end
                    end
                endcase
            end
            st_push: begin
                next_mem_req.addr = {SP_STACK_PAGE, regs.sp};
                next_mem_req.wdata = push_byte(regs, push_idx);
                next_mem_req.wr = 1'b1;
                next_regs.sp = regs.sp - 8'd1;
                next_push_idx = push_idx + 3'd1;
                if (push_idx == 3'd4) begin
                    next_regs.flag_register[FLAG_I] = 1'b1;
                    next_mem_req.wr = 1'b1;
                    next_state = st_vec_hi;
                end
            end
            st_vec_hi: begin
                next_mem_req.addr = TRAP_VEC;
                next_mem_req.rd = 1'b1;
                next_state = st_vec_lo;
            end
            st_vec_lo: begin
                next_regs.pc[15:8] = mem_rdata;
                next_mem_req.addr = TRAP_VEC + 16'd1;
                next_mem_req.rd = 1'b1;
                next_state = st_pad;
            end
            st_wait_halt: begin
                if (irq_pending) begin
                    next_halted = 1'b0;
                    next_state = st_fetch;
                end
            end
            st_pad: begin
                if (opcode == OP_SOFTWARE_TRAP && cyc_left == 4'd1) begin
                    next_regs.pc[7:0] = mem_rdata;
                end
                if (mode == bit_branch_mode && cyc_left == 4'd1) begin
                    next_regs.pc = branch_target;
                end
                if (cyc_left <= 4'd1) begin
                    next_state = st_fetch;
                end
            end
            default: next_state = st_fetch;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_fetch;
            regs <= '{acc: 8'h00, index: 8'h00, flag_register: FLAGS_RESET, sp: SP_RESET, pc: RESET_VECTOR};
            mem_req <= '0;
            opcode <= 8'h00;
            ea <= 16'h0000;
            push_idx <= 3'd0;
            cyc_left <= 4'd0;
            halted <= 1'b0;
            illegal_op <= 1'b0;
            branch_target <= 16'h0000;
            bit_operand_addr <= 8'h00;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            regs <= next_regs;
            mem_req <= next_mem_req;
            opcode <= next_opcode;
            ea <= next_ea;
            push_idx <= next_push_idx;
            cyc_left <= next_cyc_left;
            halted <= next_halted;
            illegal_op <= next_illegal;
            branch_target <= next_branch_target;
            bit_operand_addr <= next_bit_addr;
            busy <= (next_state != st_fetch) && (next_state != st_wait_halt);
        end
    end
endmodule : cpu_tail_opcode_execute
`default_nettype wire

// *** rtl/cpu_tail_pkg.sv ***
// constants and carrier types for the tail opcode execute unit
package cpu_tail_pkg;
    localparam logic [7:0] OP_SOFTWARE_TRAP = 8'h83;
    localparam logic [7:0] OP_ACC_TO_INDEX = 8'h97;
    localparam logic [7:0] OP_INDEX_TO_ACC = 8'h9F;
    localparam logic [7:0] OP_WAIT = 8'h8F;
    localparam logic [7:0] OP_TEST_DIR = 8'h3D;
    localparam logic [7:0] OP_TEST_ACC = 8'h4D;
    localparam logic [7:0] OP_TEST_IDX = 8'h5D;
    localparam logic [7:0] OP_TEST_IX1 = 8'h6D;
    localparam logic [7:0] OP_TEST_IX = 8'h7D;
    localparam logic [7:0] OP_TEST_EXT = 8'hCD;
    localparam logic [7:0] OP_TEST_IX2 = 8'hDD;
    localparam logic [7:0] OP_BIT_BRANCH_BASE = 8'h00;
    localparam int CYC_TRAP = 10;
    localparam int CYC_COPY = 2;
    localparam int CYC_WAIT = 2;
    localparam int CYC_TEST_DIR = 4;
    localparam int CYC_TEST_REG = 3;
    localparam int CYC_TEST_IX1 = 5;
    localparam int CYC_TEST_IX = 4;
    localparam int CYC_TEST_EXT = 5;
    localparam int CYC_TEST_IX2 = 6;
    localparam int CYC_BIT_BRANCH = 5;
    localparam logic [15:0] TRAP_VECTOR = 16'h1FFC;
    localparam logic [15:0] RESET_VECTOR = 16'h1FFE;
    localparam logic [7:0] SP_RESET = 8'hFF;
    localparam logic [7:0] SP_STACK_PAGE = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h08;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    typedef enum logic [2:0] {
        implied_operand_mode, direct_mode, full_address_mode,
        indexed_no_offset_mode, indexed_byte_offset_mode, indexed_word_offset_mode, bit_branch_mode
    } addr_mode_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } mem_req_t;
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] index;
        logic [7:0] flag_register;
        logic [7:0] sp;
        logic [15:0] pc;
    } cpu_regs_t;
endpackage : cpu_tail_pkg

// *** rtl/tail_opcode_decode.sv ***
// opcode to addressing mode and cycle count decoder
`timescale 1ns/10ps
`default_nettype none
module tail_opcode_decode
    import cpu_tail_pkg::*;
(
    input wire logic [7:0] opcode,
    output addr_mode_t mode,
    output logic [3:0] cycles,
    output logic known
);
    // classify the opcodes this unit executes
    always_comb begin
        mode = implied_operand_mode;
        cycles = 4'(CYC_COPY);
        known = 1'b1;
        unique case (opcode)
            OP_SOFTWARE_TRAP: cycles = 4'(CYC_TRAP);
            OP_ACC_TO_INDEX, OP_INDEX_TO_ACC: cycles = 4'(CYC_COPY);
            OP_WAIT: cycles = 4'(CYC_WAIT);
            OP_TEST_ACC, OP_TEST_IDX: cycles = 4'(CYC_TEST_REG);
            OP_TEST_DIR: begin
                mode = direct_mode;
                cycles = 4'(CYC_TEST_DIR);
            end
            OP_TEST_IX1: begin
                mode = indexed_byte_offset_mode;
                cycles = 4'(CYC_TEST_IX1);
            end
            OP_TEST_IX: begin
                mode = indexed_no_offset_mode;
                cycles = 4'(CYC_TEST_IX);
            end
            OP_TEST_EXT: begin
                mode = full_address_mode;
                cycles = 4'(CYC_TEST_EXT);
            end
            OP_TEST_IX2: begin
                mode = indexed_word_offset_mode;
                cycles = 4'(CYC_TEST_IX2);
            end
            default: begin
                if (opcode[7:4] == OP_BIT_BRANCH_BASE[7:4]) begin
                    mode = bit_branch_mode;
                    cycles = 4'(CYC_BIT_BRANCH);
                end else begin
                    known = 1'b0;
                end
            end
        endcase
    end
endmodule : tail_opcode_decode
`default_nettype wire
